// *** common/upmc_pkg.sv ***
// Package for the UART pin and miscellaneous configuration bank
package upmc_pkg;
  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_DRIVE = 6'h13;
  localparam logic [5:0] IDX_PULLUP = 6'h14;
  localparam logic [5:0] IDX_PULLDN = 6'h15;
  localparam logic [5:0] IDX_LOOP = 6'h16;
  localparam logic [5:0] IDX_IR = 6'h17;
  localparam logic [5:0] IDX_CLKDIV = 6'h18;
  localparam logic [5:0] IDX_WAKE = 6'h1F;
  // Writable bit masks
  localparam logic [15:0] MASK_DRIVE = 16'h0BFF;
  localparam logic [15:0] MASK_PULL = 16'h07FF;
  localparam logic [15:0] MASK_LOOP = 16'h0007;
  localparam logic [15:0] MASK_IR = 16'h0007;
  localparam logic [15:0] MASK_CLKDIV = 16'hFFFF;
  localparam logic [15:0] MASK_WAKE = 16'h000C;
  // Reset values
  localparam logic [15:0] RST_DRIVE = 16'h0080;
  localparam logic [15:0] RST_PULLUP = 16'h07FF;
  localparam logic [15:0] RST_PULLDN = 16'h0000;
  localparam logic [15:0] RST_LOOP = 16'h0000;
  localparam logic [15:0] RST_IR = 16'h0000;
  localparam logic [15:0] RST_CLKDIV = 16'h0000;
  localparam logic [15:0] RST_WAKE = 16'h0004;
  // Field positions
  localparam int DRV_TX_BIT = 11;
  localparam int PULL_RX_BIT = 10;
  localparam int LOOP_DTR_BIT = 2;
  localparam int LOOP_RTS_BIT = 1;
  localparam int LOOP_TX_BIT = 0;
  localparam int IR_WIDTH_BIT = 2;
  localparam int IR_INV_BIT = 1;
  localparam int IR_EN_BIT = 0;
  localparam int WAKE_RX_BIT = 3;
  localparam int WAKE_RI_BIT = 2;
  localparam int HIGH_CNT_LSB = 8;
  localparam int LOW_CNT_LSB = 0;
  localparam int GPIO_COUNT = 10;
  // Infrared pulse widths in sixteenths of a bit
  localparam logic [3:0] IR_PULSE_NARROW = 4'h3;
  localparam logic [3:0] IR_PULSE_WIDE = 4'h4;
  localparam logic [4:0] IR_BIT_TICKS = 5'h10;
  // Clock output unit time and system clock period
  localparam int CLKOUT_UNIT_PS = 41670;
  localparam int SYS_CLK_PERIOD_PS = 50000;
  localparam int CLKOUT_UNIT_RAW = CLKOUT_UNIT_PS / SYS_CLK_PERIOD_PS;
  localparam int CLKOUT_UNIT_CYC = (CLKOUT_UNIT_RAW < 1) ? 1 : CLKOUT_UNIT_RAW;
endpackage

// *** hw/upmc_config_bank.sv ***
// UART pin drive, pull, loopback, infrared, clock output and wakeup configuration bank
// Behaviour
// [R1] TX pin open drain when bit 11 set
// [R2] GPIO drive bits select push-pull or open drain
// [R3] GPIO7 drive bit resets to open drain
// [R4] Drive type applies to alternate functions too
// [R5] RX pull-up bit 10, resets enabled
// [R6] GPIO pull-ups, reset all enabled
// [R7] RX pull-down bit 10, resets disabled
// [R8] GPIO pull-downs, reset all disabled
// [R9] Pull-up wins over pull-down
// [R10] Pulls apply to alternate-function inputs too
// [R11] DTR loops to DSR when bit 2 set
// [R12] RTS loops to CTS when bit 1 set
// [R13] TX loops to receiver, pins cut off
// [R14] Infrared control bit 0 enables infrared mode
// [R15] Infrared pulse 3/16 or 4/16 bit
// [R16] Infrared bit 1 inverts receive data
// [R17] Clock output high time from bits 15:8
// [R18] Clock output low time from bits 7:0
// [R19] RX falling edge wakes when enabled
// [R20] Ring pin falling edge wakes, default on
// [R21] Software writes reserved bits as zero
// [R22] Clock divider counts one-unit enable ticks; here each tick is one 50000 ps system clock, longer than the 41670 ps unit
// [R23] Reserved bits ignore writes, read zero
//
// Implementation choice: the Wishbone register port.
module upmc_config_bank (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  // Wishbone slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  // UART core side
  input wire logic uart_txd_in,
  input wire logic uart_rts_in,
  input wire logic uart_dtr_in,
  input wire logic baud16_tick_in,
  output logic uart_rxd_out,
  output logic uart_cts_out,
  output logic uart_dsr_out,
  // GPIO logic side
  input wire logic [upmc_pkg::GPIO_COUNT-1:0] gpio_data_in,
  input wire logic [upmc_pkg::GPIO_COUNT-1:0] gpio_dir_out_in,
  input wire logic rx_is_input_in,
  input wire logic ri_is_input_in,
  // Pins
  input wire logic rx_pin_in,
  input wire logic cts_pin_in,
  input wire logic dsr_pin_in,
  input wire logic ring_indicate_wake_pin_in,
  output logic tx_pin_out,
  output logic tx_pin_oe_out,
  output logic [upmc_pkg::GPIO_COUNT-1:0] gpio_pin_out,
  output logic [upmc_pkg::GPIO_COUNT-1:0] gpio_pin_oe_out,
  output logic [upmc_pkg::GPIO_COUNT:0] pull_up_out,
  output logic [upmc_pkg::GPIO_COUNT:0] pull_down_out,
  output logic clkout_pin_out,
  // Wakeup
  output logic wake_event_out
);
  import upmc_pkg::*;

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  logic [15:0] drive_reg, pullup_reg, pulldn_reg, loop_reg, ir_reg, clkdiv_reg, wake_reg;
  logic bus_req, bus_wr;
  logic [15:0] wr_lanes;

  function automatic logic [15:0] lane_write(input logic [15:0] old, input logic [15:0] mask);
    logic [15:0] merged;
    merged = (old & ~wr_lanes) | (wb_dat_in[15:0] & wr_lanes);
    return merged & mask;
  endfunction

  function automatic logic [15:0] reg_read(input logic [5:0] idx);
    logic [15:0] val;
    val = 16'h0000;
    case (idx)
      IDX_DRIVE: val = drive_reg;
      IDX_PULLUP: val = pullup_reg;
      IDX_PULLDN: val = pulldn_reg;
      IDX_LOOP: val = loop_reg;
      IDX_IR: val = ir_reg;
      IDX_CLKDIV: val = clkdiv_reg;
      IDX_WAKE: val = wake_reg;
      default: val = 16'h0000;
    endcase
    return val;
  endfunction

  assign bus_req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
  // Write lands on the edge where the master sees ack
  assign bus_wr = wb_cyc_in & wb_stb_in & wb_we_in & wb_ack_out;
  assign wr_lanes = {{8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end else begin
      wb_ack_out <= bus_req;
      // Unmapped offsets still ack and read zero
      if (bus_req) begin
        wb_dat_out <= {16'h0000, reg_read(wb_adr_in[7:2])};
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      drive_reg <= RST_DRIVE; // see [R3]
      pullup_reg <= RST_PULLUP; // see [R5] see [R6]
      pulldn_reg <= RST_PULLDN; // see [R7] see [R8]
      loop_reg <= RST_LOOP;
      ir_reg <= RST_IR;
      clkdiv_reg <= RST_CLKDIV;
      wake_reg <= RST_WAKE; // see [R20]
    end else if (bus_wr) begin
      // Masks drop reserved bits so they always read zero; see [R23]
      case (wb_adr_in[7:2])
        IDX_DRIVE: drive_reg <= lane_write(drive_reg, MASK_DRIVE);
        IDX_PULLUP: pullup_reg <= lane_write(pullup_reg, MASK_PULL);
        IDX_PULLDN: pulldn_reg <= lane_write(pulldn_reg, MASK_PULL);
        IDX_LOOP: loop_reg <= lane_write(loop_reg, MASK_LOOP);
        IDX_IR: ir_reg <= lane_write(ir_reg, MASK_IR);
        IDX_CLKDIV: clkdiv_reg <= lane_write(clkdiv_reg, MASK_CLKDIV);
        IDX_WAKE: wake_reg <= lane_write(wake_reg, MASK_WAKE);
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Pin input synchronisers
  // ---------------------------------------------------------------
  // Order: ring, dsr, cts, rx
  logic [3:0] pin_meta_reg, pin_sync_reg, pin_prev_reg;
  logic rx_sync, cts_sync, dsr_sync, ri_sync;

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      pin_meta_reg <= 4'hF;
      pin_sync_reg <= 4'hF;
      pin_prev_reg <= 4'hF;
    end else begin
      pin_meta_reg <= {ring_indicate_wake_pin_in, dsr_pin_in, cts_pin_in, rx_pin_in};
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end

  assign rx_sync = pin_sync_reg[0];
  assign cts_sync = pin_sync_reg[1];
  assign dsr_sync = pin_sync_reg[2];
  assign ri_sync = pin_sync_reg[3];

  // ---------------------------------------------------------------
  // Infrared encode and decode
  // ---------------------------------------------------------------
  logic ir_en, ir_inv, loop_tx;
  logic [3:0] ir_phase_reg, ir_width, ir_stretch_reg;
  logic txd_prev_reg, ir_tx_pulse, rx_line;

  assign ir_en = ir_reg[IR_EN_BIT]; // see [R14]
  assign ir_inv = ir_reg[IR_INV_BIT];
  assign loop_tx = loop_reg[LOOP_TX_BIT];
  assign ir_width = ir_reg[IR_WIDTH_BIT] ? IR_PULSE_WIDE : IR_PULSE_NARROW; // see [R15]
  // Pulse sits at the start of each zero bit; the data edge cycle counts as phase 0
  assign ir_tx_pulse = ir_en & ~uart_txd_in
    & ((uart_txd_in != txd_prev_reg) | (ir_phase_reg < ir_width)); // see [R15]
  // Inversion serves receivers whose idle level is the wrong way up
  assign rx_line = rx_sync ^ ir_inv; // see [R16]

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      txd_prev_reg <= 1'b1;
      ir_phase_reg <= 4'h0;
    end else begin
      txd_prev_reg <= uart_txd_in;
      if (uart_txd_in != txd_prev_reg) begin
        ir_phase_reg <= baud16_tick_in ? 4'h1 : 4'h0;
      end else if (baud16_tick_in) begin
        ir_phase_reg <= ir_phase_reg + 4'h1;
      end
    end
  end

  // A low received pulse is stretched across one bit time
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      ir_stretch_reg <= 4'h0;
    end else if (!rx_line) begin
      ir_stretch_reg <= IR_BIT_TICKS[3:0] - 4'h1;
    end else if (baud16_tick_in && ir_stretch_reg != 4'h0) begin
      ir_stretch_reg <= ir_stretch_reg - 4'h1;
    end
  end

  // ---------------------------------------------------------------
  // Loopback and receive routing
  // ---------------------------------------------------------------
  logic rx_path;

  always_comb begin
    if (loop_tx) begin
      rx_path = uart_txd_in; // see [R13]
    end else if (ir_en) begin
      rx_path = rx_line & (ir_stretch_reg == 4'h0); // see [R14] see [R16]
    end else begin
      rx_path = rx_line; // see [R16]
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      uart_rxd_out <= 1'b1;
      uart_cts_out <= 1'b1;
      uart_dsr_out <= 1'b1;
    end else begin
      uart_rxd_out <= rx_path;
      uart_cts_out <= loop_reg[LOOP_RTS_BIT] ? uart_rts_in : cts_sync; // see [R12]
      uart_dsr_out <= loop_reg[LOOP_DTR_BIT] ? uart_dtr_in : dsr_sync; // see [R11]
    end
  end

  // ---------------------------------------------------------------
  // Output drivers and pulls
  // ---------------------------------------------------------------
  logic tx_level;
  assign tx_level = ir_en ? ir_tx_pulse : uart_txd_in;

  // Open drain drives only low; a high is left to the external pull-up
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      tx_pin_out <= 1'b1;
      tx_pin_oe_out <= 1'b0;
      gpio_pin_out <= '0;
      gpio_pin_oe_out <= '0;
      pull_up_out <= '0;
      pull_down_out <= '0;
    end else begin
      if (loop_tx) begin
        // Level follows drive type so an open-drain pin never shows high
        tx_pin_out <= ~drive_reg[DRV_TX_BIT]; // see [R13]
        tx_pin_oe_out <= 1'b0;
      end else if (drive_reg[DRV_TX_BIT]) begin
        tx_pin_out <= 1'b0; // see [R1]
        tx_pin_oe_out <= ~tx_level;
      end else begin
        tx_pin_out <= tx_level; // see [R1]
        tx_pin_oe_out <= 1'b1;
      end
      // GPIO data and direction already carry any alternate function; see [R4]
      for (int i = 0; i < GPIO_COUNT; i++) begin
        gpio_pin_out[i] <= drive_reg[i] ? 1'b0 : gpio_data_in[i]; // see [R2]
        gpio_pin_oe_out[i] <= gpio_dir_out_in[i] & ~(drive_reg[i] & gpio_data_in[i]);
      end
      // Pulls stay set whatever the pin's function; see [R10]
      pull_up_out <= pullup_reg[PULL_RX_BIT:0]; // see [R5] see [R6]
      pull_down_out <= pulldn_reg[PULL_RX_BIT:0] & ~pullup_reg[PULL_RX_BIT:0]; // see [R9]
    end
  end

  // ---------------------------------------------------------------
  // Clock output divider
  // ---------------------------------------------------------------
  localparam int UNIT_W = $clog2(CLKOUT_UNIT_CYC + 1);
  logic [UNIT_W-1:0] unit_cnt_reg;
  logic unit_tick;
  logic [7:0] div_cnt_reg, hi_count, lo_count, div_inc;

  assign unit_tick = (unit_cnt_reg == UNIT_W'(CLKOUT_UNIT_CYC - 1)); // see [R22]
  assign hi_count = clkdiv_reg[HIGH_CNT_LSB +: 8];
  assign lo_count = clkdiv_reg[LOW_CNT_LSB +: 8];
  assign div_inc = div_cnt_reg + 8'h01;

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      unit_cnt_reg <= '0;
    end else begin
      unit_cnt_reg <= unit_tick ? '0 : unit_cnt_reg + UNIT_W'(1);
    end
  end

  // A zero count holds the output in the other phase
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      clkout_pin_out <= 1'b0;
      div_cnt_reg <= 8'h00;
    end else if (unit_tick) begin
      if (clkout_pin_out && div_inc >= hi_count && lo_count != 8'h00) begin
        clkout_pin_out <= 1'b0; // see [R17]
        div_cnt_reg <= 8'h00;
      end else if (!clkout_pin_out && div_inc >= lo_count && hi_count != 8'h00) begin
        clkout_pin_out <= 1'b1; // see [R18]
        div_cnt_reg <= 8'h00;
      end else if (div_cnt_reg != 8'hFE) begin
        // Saturate below 0xFF so the incremented count never wraps to zero and stalls
        div_cnt_reg <= div_inc;
      end
    end
  end

  // ---------------------------------------------------------------
  // Remote wakeup
  // ---------------------------------------------------------------
  logic rx_fall, ri_fall;
  assign rx_fall = pin_prev_reg[0] & ~rx_sync;
  assign ri_fall = pin_prev_reg[3] & ~ri_sync;

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      wake_event_out <= 1'b0;
    end else begin
      wake_event_out <= (wake_reg[WAKE_RX_BIT] & rx_is_input_in & rx_fall) | // see [R19]
                        (wake_reg[WAKE_RI_BIT] & ri_is_input_in & ri_fall); // see [R20]
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  sequence s_write_idx(logic [5:0] idx);
    wb_cyc_in && wb_stb_in && wb_we_in && wb_ack_out && wb_adr_in[7:2] == idx
      && wb_sel_in[1:0] == 2'b11;
  endsequence

  a_tx_open_drain: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // see [R1]
    drive_reg[DRV_TX_BIT] |=> !tx_pin_out)
    else $error("TX pin drove high in open-drain mode");

  a_gpio_open_drain: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // see [R2]
    drive_reg[4] && gpio_data_in[4] |=> !gpio_pin_oe_out[4])
    else $error("GPIO open-drain pin drove a high level");

  a_gpio7_reset: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // see [R3]
    $rose(rst_b_in) |-> drive_reg[7] && !drive_reg[DRV_TX_BIT])
    else $error("Drive type reset value wrong");

  a_pull_priority: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // see [R9]
    (pull_up_out & pull_down_out) == '0)
    else $error("Pull-up and pull-down both enabled");

  a_pullup_follow: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // see [R6]
    s_write_idx(IDX_PULLUP) ##2 1'b1 |-> pull_up_out == $past(wb_dat_in[10:0], 2))
    else $error("Pull-up output did not follow write");

  a_loop_tx_rx: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // see [R13]
    loop_tx ##1 loop_tx |-> !tx_pin_oe_out && uart_rxd_out == $past(uart_txd_in))
    else $error("TX loopback path broken");

  a_loop_rts_cts: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // see [R12]
    loop_reg[LOOP_RTS_BIT] |=> uart_cts_out == $past(uart_rts_in))
    else $error("RTS to CTS loopback broken");

  a_wake_rx_edge: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // see [R19]
    wake_reg[WAKE_RX_BIT] && rx_is_input_in && $fell(rx_sync) |=> wake_event_out)
    else $error("RX falling edge gave no wakeup");

  a_wake_quiet: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // see [R20]
    !ri_fall && !rx_fall |=> !wake_event_out)
    else $error("Wakeup without a falling edge");

  a_tx_push_pull: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // see [R1]
    !loop_tx && !drive_reg[DRV_TX_BIT] |=> tx_pin_oe_out)
    else $error("Push-pull TX pin not driven");

  a_loop_dtr_dsr: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // see [R11]
    loop_reg[LOOP_DTR_BIT] |=> uart_dsr_out == $past(uart_dtr_in))
    else $error("DTR to DSR loopback broken");

  a_wake_ri_edge: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // see [R20]
    wake_reg[WAKE_RI_BIT] && ri_is_input_in && $fell(ri_sync) |=> wake_event_out)
    else $error("Ring pin falling edge gave no wakeup");
endmodule

// *** tb/testbench.sv ***
// Self-checking testbench for the UART pin configuration bank
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import upmc_pkg::*;
  logic clk_sys_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0, wb_dat_out, q;
  logic wb_ack_out, rxd, cts, dsr, rx_pin, cts_pin, dsr_pin, ri_pin, tx_pin, tx_oe, clkout;
  logic wake, tx_wire, txd = 1'b1, rts = 1'b1, dtr = 1'b1, tick = 1'b0, rx_drv = 1'b1;
  logic rx_ie = 1'b1, ri_ie = 1'b1, p_rx = 1'b1, p_cts = 1'b1, p_dsr = 1'b1, p_ri = 1'b1;
  logic [9:0] gdat = 10'h000, gdir = 10'h000, gpin, goe;
  logic [10:0] pu, pd;
  logic [15:0] shd [8];
  int err_count = 0, cmp_count = 0, cyc_cnt = 0;
  localparam logic [5:0] IDX [8] = '{IDX_DRIVE, IDX_PULLUP, IDX_PULLDN, IDX_LOOP, IDX_IR,
    IDX_CLKDIV, IDX_WAKE, 6'h20};
  localparam logic [15:0] MSK [8] = '{MASK_DRIVE, MASK_PULL, MASK_PULL, MASK_LOOP, MASK_IR,
    MASK_CLKDIV, MASK_WAKE, 16'h0000};
  localparam logic [15:0] RST [8] = '{RST_DRIVE, RST_PULLUP, RST_PULLDN, RST_LOOP, RST_IR,
    RST_CLKDIV, RST_WAKE, 16'h0000};
  always #25 clk_sys_in = ~clk_sys_in;
  upmc_config_bank u_upmc_config_bank (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
    .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
    .wb_dat_in(wdat), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .uart_txd_in(txd),
    .uart_rts_in(rts), .uart_dtr_in(dtr), .baud16_tick_in(tick), .uart_rxd_out(rxd),
    .uart_cts_out(cts), .uart_dsr_out(dsr), .gpio_data_in(gdat), .gpio_dir_out_in(gdir),
    .rx_is_input_in(rx_ie), .ri_is_input_in(ri_ie), .rx_pin_in(rx_pin), .cts_pin_in(cts_pin),
    .dsr_pin_in(dsr_pin), .ring_indicate_wake_pin_in(ri_pin), .tx_pin_out(tx_pin),
    .tx_pin_oe_out(tx_oe), .gpio_pin_out(gpin), .gpio_pin_oe_out(goe), .pull_up_out(pu),
    .pull_down_out(pd), .clkout_pin_out(clkout), .wake_event_out(wake));
  upmc_serial_peer u_upmc_serial_peer (.clk_in(clk_sys_in), .rx_drv_en_in(rx_drv),
    .rx_val_in(p_rx), .cts_val_in(p_cts), .dsr_val_in(p_dsr), .ri_val_in(p_ri),
    .tx_pin_in(tx_pin), .tx_oe_in(tx_oe), .pu_rx_in(pu[10]), .pd_rx_in(pd[10]),
    .rx_pin_out(rx_pin), .cts_pin_out(cts_pin), .dsr_pin_out(dsr_pin), .ri_pin_out(ri_pin),
    .tx_wire_out(tx_wire));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic close_out;
    $display("mismatches %0d of %0d compares", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s got %0h exp %0h", $time, msg, got, exp);
    end
  endtask
  // Classic single cycle; the shadow copy follows only the enabled byte lanes
  task automatic wb(input logic w, input int i, input logic [15:0] d, input logic [1:0] s);
    int n;
    logic [15:0] lm;
    lm = {{8{s[1]}}, {8{s[0]}}};
    @(posedge clk_sys_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {IDX[i], 2'b00};
    sel <= {2'b00, s};
    wdat <= {16'h0000, d};
    n = 0;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (wb_ack_out !== 1'b1 && n < 40);
    if (wb_ack_out !== 1'b1) begin
      err_count++;
      $display("[FAIL] %0t bus timeout", $time);
    end
    q = wb_dat_out;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (w) shd[i] = (shd[i] & ~lm) | (d & MSK[i] & lm);
  endtask
  task automatic rd(input int i);
    wb(1'b0, i, 16'h0000, 2'b11);
    chk(q, {16'h0000, shd[i]}, "register read");
  endtask
  task automatic pins_chk;
    logic [9:0] od;
    od = shd[0][9:0];
    chk(pu, shd[1][10:0], "pull up");
    chk(pd, shd[2][10:0] & ~shd[1][10:0], "pull down");
    chk(goe, gdir & ~(od & gdat), "gpio enable");
    chk(gpin & gdir & ~od, gdat & gdir & ~od, "gpio level");
    chk(gpin & od, 10'h000, "gpio open drain");
    if (shd[4][0] == 1'b0) chk(tx_oe, !(shd[3][0] | (shd[0][11] & txd)), "tx enable");
    if (shd[4][0] == 1'b0 && shd[3][0] == 1'b0) chk(tx_wire, txd, "tx wire");
  endtask
  task automatic wake_try(input logic [15:0] w, input logic on_rx, input logic ie, input int e);
    int n;
    wb(1'b1, 6, w, 2'b11);
    rx_ie <= ie;
    ri_ie <= ie;
    p_rx <= 1'b1;
    p_ri <= 1'b1;
    repeat (5) @(posedge clk_sys_in);
    if (on_rx) p_rx <= 1'b0;
    else p_ri <= 1'b0;
    n = 0;
    repeat (8) begin
      @(posedge clk_sys_in);
      #1;
      n += wake;
    end
    chk(n, e, "wake pulses");
  endtask
  // Hang guard sized well above the several hundred cycles the sequence needs
  always @(posedge clk_sys_in) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      err_count++;
      $display("[FAIL] %0t run timeout", $time);
      close_out;
    end
  end
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    int c, h, l;
    void'($urandom(32'h32AE3E58));
    for (int i = 0; i < 8; i++) shd[i] = RST[i];
    repeat (12) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    for (int i = 0; i < 8; i++) rd(i);
    #1;
    pins_chk;
    for (int i = 0; i < 8; i++) begin
      wb(1'b1, i, 16'hFFFF, 2'b11);
      rd(i);
    end
    for (int k = 0; k < 40; k++) begin
      @(posedge clk_sys_in);
      gdat <= 10'($urandom);
      gdir <= 10'($urandom);
      txd <= 1'($urandom);
      tick <= 1'($urandom);
      c = $urandom_range(6);
      wb(1'b1, c, 16'($urandom) & MSK[c], 2'($urandom_range(1, 3)));
      rd(c);
      #1;
      pins_chk;
    end
    wb(1'b1, 0, RST_DRIVE, 2'b11);
    wb(1'b1, 4, 16'h0000, 2'b11);
    wb(1'b1, 3, 16'h0007, 2'b11);
    for (int k = 0; k < 10; k++) begin
      @(posedge clk_sys_in);
      txd <= 1'($urandom);
      rts <= 1'($urandom);
      dtr <= 1'($urandom);
      p_rx <= 1'($urandom);
      @(posedge clk_sys_in);
      #1;
      chk({rxd, cts, dsr, tx_oe}, {txd, rts, dtr, 1'b0}, "loopback");
    end
    wb(1'b1, 3, 16'h0000, 2'b11);
    for (int v = 0; v < 2; v++) begin
      wb(1'b1, 4, 16'(v * 2), 2'b11);
      @(posedge clk_sys_in);
      p_rx <= 1'($urandom);
      p_cts <= 1'($urandom);
      p_dsr <= 1'($urandom);
      repeat (3) @(posedge clk_sys_in);
      #1;
      chk({rxd, cts, dsr}, {rx_pin ^ 1'(v), cts_pin, dsr_pin}, "pin path");
    end
    // Released RX line settles through the pulls; pull-down first, then both
    for (int u = 0; u < 2; u++) begin
      wb(1'b1, 1, u ? 16'h07FF : 16'h0000, 2'b11);
      rx_drv <= 1'b0;
      wb(1'b1, 2, 16'h0400, 2'b11);
      repeat (4) @(posedge clk_sys_in);
      #1;
      chk(rxd, 1'(u) ^ shd[4][1], "released rx line");
    end
    for (int w = 0; w < 2; w++) begin
      @(posedge clk_sys_in);
      txd <= 1'b1;
      tick <= 1'b1;
      rx_drv <= 1'b1;
      wb(1'b1, 4, 16'(w * 4 + 1), 2'b11);
      repeat (20) @(posedge clk_sys_in);
      txd <= 1'b0;
      c = 0;
      repeat (14) begin
        @(posedge clk_sys_in);
        #1;
        c += tx_pin;
      end
      chk(c, w ? IR_PULSE_WIDE : IR_PULSE_NARROW, "ir pulse width");
    end
    wb(1'b1, 4, 16'h0000, 2'b11);
    for (int k = 0; k < 3; k++) begin
      h = $urandom_range(1, 8);
      l = $urandom_range(1, 8);
      wb(1'b1, 5, 16'(h * 256 + l), 2'b11);
      #1;
      c = 0;
      while (clkout !== 1'b0 && c < 40) begin
        @(posedge clk_sys_in);
        #1;
        c++;
      end
      while (clkout !== 1'b1 && c < 80) begin
        @(posedge clk_sys_in);
        #1;
        c++;
      end
      c = 0;
      while (clkout === 1'b1 && c < 40) begin
        @(posedge clk_sys_in);
        #1;
        c++;
      end
      chk(c, h * CLKOUT_UNIT_CYC, "clock high");
      c = 0;
      while (clkout === 1'b0 && c < 40) begin
        @(posedge clk_sys_in);
        #1;
        c++;
      end
      chk(c, l * CLKOUT_UNIT_CYC, "clock low");
    end
    wake_try(16'h0004, 1'b0, 1'b1, 1);
    wake_try(16'h0004, 1'b0, 1'b0, 0);
    wake_try(16'h0000, 1'b0, 1'b1, 0);
    wake_try(16'h0008, 1'b1, 1'b1, 1);
    wake_try(16'h0004, 1'b1, 1'b1, 0);
    close_out;
  end
endmodule

// *** tb/upmc_serial_peer.sv ***
// Serial peer model driving the UART side pins and resolving released lines
module upmc_serial_peer (
  // Bench control
  input wire logic clk_in,
  input wire logic rx_drv_en_in,
  input wire logic rx_val_in,
  input wire logic cts_val_in,
  input wire logic dsr_val_in,
  input wire logic ri_val_in,
  // Device pins
  input wire logic tx_pin_in,
  input wire logic tx_oe_in,
  input wire logic pu_rx_in,
  input wire logic pd_rx_in,
  output logic rx_pin_out,
  output logic cts_pin_out,
  output logic dsr_pin_out,
  output logic ri_pin_out,
  output logic tx_wire_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic flip_reg = 1'b0;
  always_ff @(posedge clk_in) flip_reg <= ~flip_reg;
  // Board pull-up on TX, so an open-drain release reads high
  assign tx_wire_out = tx_oe_in ? tx_pin_in : 1'b1;
  // A floating RX line is shown as a toggle so it never passes for a steady level
  assign rx_pin_out = rx_drv_en_in ? rx_val_in : pu_rx_in ? 1'b1 : pd_rx_in ? 1'b0 : flip_reg;
  assign cts_pin_out = cts_val_in;
  assign dsr_pin_out = dsr_val_in;
  assign ri_pin_out = ri_val_in;
endmodule
